//--- rtl/cpc_top.v
// protection configuration register, threshold comparators and event classification
// Overview of operation
// - host writes protection register; stored selections steer threshold comparisons
// - undervoltage field bits 1:0, 75 to 90 percent in 5 percent steps
// - overvoltage field bits 3:2, 110 to 130 percent, reset code 10
// - all thresholds scale from the present output setpoint
// - output stage held off until ramp reaches pre-bias voltage
// - turn-off delay max below turn-on max; falling rate independent
// - overcurrent, overvoltage, overtemperature, tracking are faults; undervoltage is error
// - near-overtemperature and output-good loss are warnings
// - good window high 110 or 105, low 90 or 95 percent
`timescale 1ns/100ps
`default_nettype none
`include "cpc_defines.vh"
module cpc_top #(
	parameter VW = 12
) (
	input  wire          clock,
	input  wire          rst,
	input  wire          reg_wr,
	input  wire [7:0]    reg_wdata,
	input  wire          run_active,
	input  wire [VW-1:0] setpoint,
	input  wire [VW-1:0] vout_meas,
	input  wire [VW-1:0] ramp_ref,
	input  wire          ramp_start,
	input  wire          overcurrent,
	input  wire          overtemp,
	input  wire          near_overtemp,
	input  wire          track_fail,
	input  wire          steady_state,
	input  wire [2:0]    fall_rate_in,
	input  wire [5:0]    toff_delay_in,
	input  wire [7:0]    ton_delay_in,
	output reg  [7:0]    reg_rdata,
	output reg           fault_flag,
	output reg           error_flag,
	output reg           warning_flag,
	output reg           output_good_flag,
	output reg           drive_enable,
	output reg  [2:0]    fall_rate,
	output reg  [5:0]    toff_delay,
	output reg  [7:0]    ton_delay
);
	// =====================================================
	// constants held at register width
	localparam [7:0] RESET_VAL = `CPC_RESET_VAL;
	localparam [7:0] WR_MASK   = `CPC_WR_MASK;
	// =====================================================
	// protection_threshold_config register
	reg  [5:0] cfg_r;
	wire [5:0] cfg_nxt;
	wire       wr_accept;
	wire [5:0] wr_value;
	// writes are dropped while the modulator switches
	assign wr_accept = reg_wr && !run_active;
	assign wr_value  = reg_wdata[5:0] & WR_MASK[5:0];
	assign cfg_nxt   = wr_accept ? wr_value : cfg_r;
	always @(posedge clock)
	begin
		if (rst)
			cfg_r <= RESET_VAL[5:0];
		else
			cfg_r <= cfg_nxt;
	end
	// bits 7:6 are not stored
	wire [1:0] undervoltage_level_select;
	wire [1:0] overvoltage_level_select;
	wire       good_window_low_select;
	wire       good_window_high_select;
	assign undervoltage_level_select = cfg_r[`CPC_UV_LSB+1:`CPC_UV_LSB];
	assign overvoltage_level_select  = cfg_r[`CPC_OV_LSB+1:`CPC_OV_LSB];
	assign good_window_low_select    = cfg_r[`CPC_PGL_BIT];
	assign good_window_high_select   = cfg_r[`CPC_PGH_BIT];
	// =====================================================
	// percentages selected by the fields
	wire [7:0] uv_pct;
	reg  [7:0] ov_pct;
	wire [7:0] pgh_pct;
	wire [7:0] pgl_pct;
	// window limits are fixed pairs picked by one bit each
	assign uv_pct  = `CPC_UV_BASE + `CPC_UV_STEP * {6'h00, undervoltage_level_select};
	assign pgh_pct = good_window_high_select ? `CPC_PGH_LO : `CPC_PGH_HI;
	assign pgl_pct = good_window_low_select ? `CPC_PGL_HI : `CPC_PGL_LO;
	// overvoltage codes are not evenly spaced, so a table
	always @*
	begin
		case (overvoltage_level_select)
			2'b00:   ov_pct = `CPC_OV_PCT0;
			2'b01:   ov_pct = `CPC_OV_PCT1;
			2'b10:   ov_pct = `CPC_OV_PCT2;
			2'b11:   ov_pct = `CPC_OV_PCT3;
			default: ov_pct = `CPC_OV_PCT2;
		endcase
	end
	// =====================================================
	// absolute levels follow the setpoint
	// levels are recomputed every cycle, so margining moves them at once
	wire [VW-1:0] uv_lvl;
	wire [VW-1:0] ov_lvl;
	wire [VW-1:0] pgh_lvl;
	wire [VW-1:0] pgl_lvl;
	// one scaler per threshold: uv, ov, good high, good low
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_thr
			wire [7:0]    pct;
			wire [VW-1:0] lvl;
			assign pct = (gi == 0) ? uv_pct : (gi == 1) ? ov_pct : (gi == 2) ? pgh_pct : pgl_pct;
			cpc_threshold_calc #(
				.VW       (VW)
			) u_calc (
				.setpoint (setpoint),
				.percent  (pct),
				.level    (lvl)
			);
		end
	endgenerate
	assign uv_lvl  = g_thr[0].lvl;
	assign ov_lvl  = g_thr[1].lvl;
	assign pgh_lvl = g_thr[2].lvl;
	assign pgl_lvl = g_thr[3].lvl;
	// =====================================================
	// classification
	wire ov_trip;
	wire uv_trip;
	wire above_window;
	wire below_window;
	wire in_window;
	// undervoltage and the good window only count once the output is steady
	assign ov_trip      = vout_meas > ov_lvl;
	assign uv_trip      = steady_state && (vout_meas < uv_lvl);
	assign above_window = vout_meas > pgh_lvl;
	assign below_window = vout_meas < pgl_lvl;
	assign in_window    = !above_window && !below_window;
	// =====================================================
	// pre-bias hold-off
	reg hold_r;
	reg hold_nxt;
	// stay off until the commanded ramp reaches the output already present
	always @*
	begin
		hold_nxt = hold_r;
		if (ramp_start)
			hold_nxt = 1'b1;
		else if (hold_r && (ramp_ref >= vout_meas))
			hold_nxt = 1'b0;
	end
	always @(posedge clock)
	begin
		if (rst)
			hold_r <= 1'b1;
		else
			hold_r <= hold_nxt;
	end
	// =====================================================
	// next values of the registered outputs
	wire       fault_nxt;
	wire       error_nxt;
	wire       warning_nxt;
	wire       good_nxt;
	wire       drive_nxt;
	wire [7:0] rdata_nxt;
	wire [2:0] fall_rate_nxt;
	wire [5:0] toff_delay_nxt;
	wire [7:0] ton_delay_nxt;
	assign fault_nxt      = overcurrent | ov_trip | overtemp | track_fail;
	assign error_nxt      = uv_trip;
	assign good_nxt       = steady_state & in_window;
	assign warning_nxt    = near_overtemp | (steady_state & ~in_window);
	assign drive_nxt      = ~hold_r & ~ramp_start;
	// read-back already shows a write taken in this cycle
	assign rdata_nxt      = {2'b00, cfg_nxt};
	assign fall_rate_nxt  = fall_rate_in;
	// turn-off delay field is narrower than the turn-on field
	assign toff_delay_nxt = (toff_delay_in > `CPC_TOFF_MAX_MS) ? `CPC_TOFF_MAX_MS : toff_delay_in;
	assign ton_delay_nxt  = ton_delay_in;
	// =====================================================
	// event flags, drive enable and read-back
	always @(posedge clock)
	begin
		if (rst)
		begin
			fault_flag       <= 1'b0;
			error_flag       <= 1'b0;
			warning_flag     <= 1'b0;
			output_good_flag <= 1'b0;
			drive_enable     <= 1'b0;
			reg_rdata        <= RESET_VAL;
		end
		else
		begin
			fault_flag       <= fault_nxt;
			error_flag       <= error_nxt;
			warning_flag     <= warning_nxt;
			output_good_flag <= good_nxt;
			drive_enable     <= drive_nxt;
			reg_rdata        <= rdata_nxt;
		end
	end
	// =====================================================
	// ramp and delay settings
	always @(posedge clock)
	begin
		if (rst)
		begin
			fall_rate  <= 3'h0;
			toff_delay <= 6'h00;
			ton_delay  <= 8'h00;
		end
		else
		begin
			fall_rate  <= fall_rate_nxt;
			toff_delay <= toff_delay_nxt;
			ton_delay  <= ton_delay_nxt;
		end
	end
endmodule // cpc_top
`default_nettype wire

//--- inc/cpc_defines.vh
// constants for the converter protection configuration block
`ifndef CPC_DEFINES_VH
`define CPC_DEFINES_VH
// =====================================================
// register field layout
`define CPC_REG_W        8
`define CPC_RESET_VAL    8'h08
`define CPC_WR_MASK      8'h3f
`define CPC_UV_LSB       0
`define CPC_OV_LSB       2
`define CPC_PGL_BIT      4
`define CPC_PGH_BIT      5
// =====================================================
// level encodings in percent of setpoint
`define CPC_UV_BASE      8'h4b
`define CPC_UV_STEP      8'h05
`define CPC_OV_PCT0      8'h6e
`define CPC_OV_PCT1      8'h78
// code 10 level: a plain default between the codes 01 and 11 levels
`define CPC_OV_PCT2      8'h7d
`define CPC_OV_PCT3      8'h82
`define CPC_PGH_HI       8'h6e
`define CPC_PGH_LO       8'h69
`define CPC_PGL_HI       8'h5f
`define CPC_PGL_LO       8'h5a
`define CPC_PCT_DIV      7'h64
// =====================================================
// ramp and delay limits
`define CPC_TON_MAX_MS   8'hff
`define CPC_TOFF_MAX_MS  6'h3f
`endif

//--- rtl/cpc_threshold_calc.v
// percentage to absolute threshold scaler
`timescale 1ns/100ps
`default_nettype none
`include "cpc_defines.vh"
module cpc_threshold_calc #(
	parameter VW = 12
) (
	input  wire [VW-1:0] setpoint,
	input  wire [7:0]    percent,
	output wire [VW-1:0] level
);
	wire [VW+7:0] prod;
	wire [VW+7:0] quot;
	assign prod  = setpoint * percent;
	assign quot  = prod / `CPC_PCT_DIV;
	assign level = quot[VW-1:0];
endmodule // cpc_threshold_calc
`default_nettype wire

//--- verification/cpc_load.sv
// load model: pre-biased output that follows the ramp once driven
`timescale 1ns/100ps
`default_nettype none
module cpc_load (
	input  wire logic        drive_enable,
	input  wire logic [11:0] ramp_ref,
	input  wire logic [11:0] bias,
	output logic      [11:0] vout_meas
);
	assign vout_meas = drive_enable ? ramp_ref : bias;
endmodule // cpc_load
`default_nettype wire

//--- verification/cpc_monitor.sv
// assertion checker for the protection config block
`timescale 1ns/100ps
`default_nettype none
module cpc_monitor (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       run_active,
	input wire logic       overcurrent,
	input wire logic       overtemp,
	input wire logic       near_overtemp,
	input wire logic       steady_state,
	input wire logic [7:0] reg_rdata,
	input wire logic       fault_flag,
	input wire logic       error_flag,
	input wire logic       warning_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_spare_zero: assert property (reg_rdata[7:6] == 2'b00) else $error("spare bits set");
	chk_run_lock: assert property (run_active |=> $stable(reg_rdata)) else $error("locked write");
	chk_write_take: assert property (reg_wr && !run_active |=> reg_rdata == ($past(reg_wdata) & 8'h3f)) else $error("wr");
	chk_oc_fault: assert property (overcurrent |=> fault_flag) else $error("oc fault");
	chk_ot_fault: assert property (overtemp |=> fault_flag) else $error("ot fault");
	chk_temp_warn: assert property (near_overtemp |=> warning_flag) else $error("warn");
	chk_err_idle: assert property (!steady_state |=> !error_flag) else $error("error");
	chk_warn_clear: assert property (!near_overtemp && !steady_state |=> !warning_flag) else $error("wclr");
endmodule // cpc_monitor
bind cpc_top cpc_monitor chk (.clock, .rst, .reg_wr, .reg_wdata, .run_active, .overcurrent, .overtemp,
	.near_overtemp, .steady_state, .reg_rdata, .fault_flag, .error_flag, .warning_flag);
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the protection config block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clock = 0, rst = 1, wr = 0, run = 0, rs = 0, oc = 0, ot = 0, nt = 0, tf = 0, ss = 1;
	logic [7:0]  wd = 8'h00, rd;
	logic [11:0] sp = 12'h3e8, bias = 12'h000, rr = 12'h000, vo;
	logic        ff, ef, wf, gf, de;
	logic [2:0]  fr = 3'h0, frq;
	logic [5:0]  tod = 6'h00, todq;
	logic [7:0]  tnd = 8'h00, tndq;
	int          errors = 0, checks_done = 0;
	cpc_top #(.VW(12)) uut (.clock, .rst, .reg_wr(wr), .reg_wdata(wd), .run_active(run), .setpoint(sp),
		.vout_meas(vo), .ramp_ref(rr), .ramp_start(rs), .overcurrent(oc), .overtemp(ot), .near_overtemp(nt),
		.track_fail(tf), .steady_state(ss), .fall_rate_in(fr), .toff_delay_in(tod), .ton_delay_in(tnd),
		.reg_rdata(rd), .fault_flag(ff), .error_flag(ef), .warning_flag(wf), .output_good_flag(gf),
		.drive_enable(de), .fall_rate(frq), .toff_delay(todq), .ton_delay(tndq));
	cpc_load ld (.drive_enable(de), .ramp_ref(rr), .bias, .vout_meas(vo));
	initial forever #20 clock = ~clock;
	// ==========
	// tasks
	task automatic chk(input string n, input logic [11:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr8(input logic [7:0] d, input logic r);
		@(posedge clock);
		{wr, wd, run} <= {1'b1, d, r};
		@(posedge clock);
		wr <= 0;
		#1;
	endtask
	// flags compared as {fault, error, warning, good}
	task automatic go(input logic [11:0] b, input logic [3:0] ev, e);
		@(posedge clock);
		// a driven output follows the ramp, so both carry the level
		{bias, rr} <= {b, b};
		{oc, ot, tf, nt} <= ev;
		@(posedge clock);
		#1;
		chk("flags", {ff, ef, wf, gf}, e);
	endtask
	task automatic print_verdict;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========
	// tests
	initial
	begin
		repeat (16) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		#1;
		chk("cfg", rd, 8'h08);
		go(12'h2ed, 4'h0, 4'b0110);
		go(12'h3e8, 4'h0, 4'b0001);
		go(12'h44d, 4'h0, 4'b0010);
		wr8(8'hff, 0);
		chk("cfg", rd, 8'h3f);
		wr8(8'h00, 1);
		chk("cfg", rd, 8'h3f);
		go(12'h515, 4'h0, 4'b1010);
		go(12'h514, 4'h0, 4'b0010);
		go(12'h383, 4'h0, 4'b0110);
		go(12'h41a, 4'h0, 4'b0001);
		go(12'h41b, 4'h0, 4'b0010);
		@(posedge clock);
		sp <= 12'h7d0;
		go(12'ha29, 4'h0, 4'b1010);
		for (int i = 0; i < 3; i++)
			go(12'h7d0, 4'h8 >> i, 4'b1001);
		go(12'h7d0, 4'h1, 4'b0011);
		@(posedge clock);
		ss <= 0;
		go(12'h000, 4'h0, 4'b0000);
		@(posedge clock);
		{bias, rr, rs} <= {12'h1f4, 12'h190, 1'b1};
		@(posedge clock);
		rs <= 0;
		repeat (2) @(posedge clock);
		#1;
		chk("drive", de, 1'b0);
		@(posedge clock);
		rr <= 12'h258;
		repeat (2) @(posedge clock);
		#1;
		chk("drive", de, 1'b1);
		wr8({rd[7:2], 2'b01}, 0);
		chk("cfg", rd, 8'h3d);
		@(posedge clock);
		{fr, tod, tnd} <= {3'h5, 6'h3f, 8'hff};
		@(posedge clock);
		#1;
		chk("fall", frq, 3'h5);
		chk("toff", todq, 6'h3f);
		chk("ton", tndq, 8'hff);
		@(posedge clock);
		fr <= 3'h2;
		@(posedge clock);
		#1;
		chk("fall", frq, 3'h2);
		chk("toff", todq, 6'h3f);
		print_verdict;
	end
	initial
	begin
		#100000;
		errors++;
		print_verdict;
	end
endmodule // tb
`default_nettype wire
